// ### rtl/screwdriver_soft_start_pkg.sv
// constants for the screwdriver soft-start and protection controller
package screwdriver_soft_start_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int ENTER_MS = 2000;
  localparam int ADV_MS = 1000;
  localparam int LOCK_MS = 10000;
  localparam int TENTH_MS = 100;
  localparam int CW = 27;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [31:0] STATUS_OFF = 32'h0000_0000;
  localparam logic [31:0] MASK_OFF = 32'h0000_0004;
  localparam logic [31:0] CONFIG_OFF = 32'h0000_0008;
  localparam logic [31:0] STATE_OFF = 32'h0000_000c;
  localparam int EVT_W = 7;
  localparam int EVT_START = 6;
  localparam int CFG_LVL_LSB = 8;
  localparam int ST_MENU_LSB = 4;
  localparam int ST_RUN = 8;
  localparam int ST_SOFT = 9;
  localparam int ST_SPD_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // settings and reset values
  // ----------------------------------------
  localparam logic [6:0] RAMP_MAX = 7'h63;
  localparam logic [3:0] LVL_MAX = 4'h9;
  localparam logic [6:0] RAMP_RST = 7'h00;
  localparam logic [3:0] LVL_RST = 4'h0;
  localparam logic [6:0] SPD_FULL = 7'h64;
  // level 1 runs at 30 percent and level 9 at 90 percent, evenly spread between
  localparam logic [6:0] SPD_BASE = 7'h1e;
  localparam logic [6:0] SPD_SPAN = 7'h3c;
  // ----------------------------------------
  // fault codes, equal to the shown digit
  // ----------------------------------------
  localparam logic [3:0] F_NONE = 4'h0;
  localparam logic [3:0] F_UV = 4'h3;
  localparam logic [3:0] F_OT = 4'h4;
  localparam logic [3:0] F_STALL = 4'h5;
  localparam logic [3:0] F_PUSH = 4'h7;
  localparam logic [3:0] F_BRAKE = 4'h8;
  localparam logic [3:0] F_FLASH = 4'h9;
  // ----------------------------------------
  // display characters
  // ----------------------------------------
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_FAULT = 8'h45;
  localparam logic [7:0] CH_LEVEL = 8'h4c;
  localparam logic [7:0] CH_RP0 = 8'h52;
  localparam logic [7:0] CH_RP1 = 8'h43;
  localparam logic [7:0] CH_SP0 = 8'h53;
  localparam logic [7:0] CH_SP1 = 8'h50;
  typedef enum logic [1:0] {
    M_NORMAL = 2'b00,
    M_RAMP = 2'b01,
    M_RATE = 2'b10
  } menu_t;
endpackage

// ### rtl/screwdriver_soft_start_ctrl.sv
// soft-start, menu, protection and register logic of the screwdriver controller
// Notes on behaviour
// - start_out is high whenever the motor has been started and runs.
// - brake_out is high whenever the tool reports its braked condition.
// - reverse_out is high whenever the motor runs in reverse.
// - both buttons held for 2 s enter the ramp time menu and show its prompt.
// - the ramp time stays within 0.0 to 9.9 s, up raising and down lowering it.
// - in the ramp menu both buttons held for 1 s advance to the rate level menu.
// - in the rate menu the buttons step the level over full rate and levels 1 to 9.
// - level 0 disables the soft start so the motor runs at full speed at once.
// - with a reduced level chosen the display shows that level.
// - undervoltage stops the motor, shows code 3, locks 10 s, then recovers.
// - overtemperature stops the motor, shows code 4, locks 10 s, then recovers.
// - a stall while running stops the motor, shows code 5, locks 10 s, then recovers.
// - a push lever change while running stops and shows code 7 until it is put back.
// - a brake signal before a start stops and shows code 8 until it is removed.
// - flash failure stops the motor, shows code 9, locks 10 s, then recovers.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
module screwdriver_soft_start_ctrl #(
  parameter int ENTER_CYC = screwdriver_soft_start_pkg::ENTER_MS * screwdriver_soft_start_pkg::CLK_KHZ,
  parameter int ADV_CYC = screwdriver_soft_start_pkg::ADV_MS * screwdriver_soft_start_pkg::CLK_KHZ,
  parameter int LOCK_CYC = screwdriver_soft_start_pkg::LOCK_MS * screwdriver_soft_start_pkg::CLK_KHZ,
  parameter int TENTH_CYC = screwdriver_soft_start_pkg::TENTH_MS * screwdriver_soft_start_pkg::CLK_KHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // panel and tool
  input wire logic btn_up,
  input wire logic btn_down,
  input wire logic trigger,
  input wire logic reverse_sel,
  input wire logic push_lever,
  input wire logic brake_in,
  input wire logic undervolt,
  input wire logic overtemp,
  input wire logic stall,
  input wire logic flash_fail,
  // relay outputs, motor and display
  output logic start_out,
  output logic brake_out,
  output logic reverse_out,
  output logic [6:0] motor_speed,
  output logic [7:0] disp_left,
  output logic [7:0] disp_right,
  output logic irq,
  // axi4-lite slave
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int CW = screwdriver_soft_start_pkg::CW;
  localparam int EW = screwdriver_soft_start_pkg::EVT_W;

  function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] digit(logic [3:0] v);
    return screwdriver_soft_start_pkg::CH_ZERO + {4'h0, v};
  endfunction

  function automatic logic [6:0] reduced(logic [3:0] lvl);
    logic [9:0] p;
    // eight equal steps over the span; a half percent is rounded down
    p = ({6'h0, lvl} - 10'h001) * {3'h0, screwdriver_soft_start_pkg::SPD_SPAN};
    p = p / {6'h0, screwdriver_soft_start_pkg::LVL_MAX - 4'h1};
    return screwdriver_soft_start_pkg::SPD_BASE + p[6:0];
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  screwdriver_soft_start_pkg::menu_t menu_q, menu_d;
  logic up_q, dn_q, hold_done_q, shown_q, run_q, soft_q, lever_q;
  logic [CW-1:0] hold_cnt_q, lock_cnt_q, tenth_cnt_q;
  logic [6:0] ramp_q, ramp_d, left_q, speed_q;
  logic [3:0] level_q, level_d, fault_q, fault_d;
  logic [EW-1:0] status_q, mask_q;
  logic [7:0] dl_q, dr_q;
  logic start_q, brake_q, rev_q, irq_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_got_q, w_got_q;
  logic [31:0] waddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // ----------------------------------------
  // buttons and menu
  // ----------------------------------------
  wire both = btn_up & btn_down;
  wire up_press = btn_up & ~up_q & ~btn_down;
  wire dn_press = btn_down & ~dn_q & ~btn_up;
  wire in_normal = menu_q == screwdriver_soft_start_pkg::M_NORMAL;
  wire in_ramp = menu_q == screwdriver_soft_start_pkg::M_RAMP;
  wire in_rate = menu_q == screwdriver_soft_start_pkg::M_RATE;
  wire [CW-1:0] hold_lim = in_normal ? CW'(ENTER_CYC - 1) : CW'(ADV_CYC - 1);
  // the done flag stops a long hold from walking through every menu
  wire hold_hit = both & ~hold_done_q & (hold_cnt_q == hold_lim);
  wire [CW-1:0] hold_cnt_d = (both & ~hold_done_q & ~hold_hit) ? hold_cnt_q + 1'b1 : '0;
  wire hold_done_d = both & (hold_done_q | hold_hit);
  wire shown_d = ~hold_hit & (shown_q | ((in_ramp | in_rate) & (up_press | dn_press)));

  always_comb begin
    menu_d = menu_q;
    if (hold_hit) begin
      unique case (menu_q)
        screwdriver_soft_start_pkg::M_NORMAL: menu_d = screwdriver_soft_start_pkg::M_RAMP;
        screwdriver_soft_start_pkg::M_RAMP: menu_d = screwdriver_soft_start_pkg::M_RATE;
        screwdriver_soft_start_pkg::M_RATE: menu_d = screwdriver_soft_start_pkg::M_NORMAL;
        default: menu_d = screwdriver_soft_start_pkg::M_NORMAL;
      endcase
    end
  end

  // ----------------------------------------
  // settings, also writable over the bus
  // ----------------------------------------
  wire cfg_wr = bvalid_q == 1'b0 && aw_got_q && w_got_q && waddr_q == screwdriver_soft_start_pkg::CONFIG_OFF;
  wire [31:0] cfg_rd = {20'h0, level_q, 1'b0, ramp_q};
  wire [31:0] cfg_new = wmerge(cfg_rd, wdata_q, wstrb_q);
  wire [6:0] cfg_ramp = cfg_new[6:0];
  wire [3:0] cfg_lvl = cfg_new[screwdriver_soft_start_pkg::CFG_LVL_LSB +: 4];

  always_comb begin
    ramp_d = ramp_q;
    level_d = level_q;
    if (cfg_wr) begin
      ramp_d = (cfg_ramp > screwdriver_soft_start_pkg::RAMP_MAX) ? screwdriver_soft_start_pkg::RAMP_MAX : cfg_ramp;
      level_d = (cfg_lvl > screwdriver_soft_start_pkg::LVL_MAX) ? screwdriver_soft_start_pkg::LVL_MAX : cfg_lvl;
    end else if (in_ramp & up_press & (ramp_q != screwdriver_soft_start_pkg::RAMP_MAX)) begin
      ramp_d = ramp_q + 7'h01;
    end else if (in_ramp & dn_press & (ramp_q != 7'h00)) begin
      ramp_d = ramp_q - 7'h01;
    end else if (in_rate & up_press & (level_q != screwdriver_soft_start_pkg::LVL_MAX)) begin
      level_d = level_q + 4'h1;
    end else if (in_rate & dn_press & (level_q != 4'h0)) begin
      level_d = level_q - 4'h1;
    end
  end

  // ----------------------------------------
  // protection
  // ----------------------------------------
  wire no_fault = fault_q == screwdriver_soft_start_pkg::F_NONE;
  wire timed = fault_q == screwdriver_soft_start_pkg::F_UV || fault_q == screwdriver_soft_start_pkg::F_OT
    || fault_q == screwdriver_soft_start_pkg::F_STALL || fault_q == screwdriver_soft_start_pkg::F_FLASH;
  wire start_req = trigger & ~run_q & no_fault;
  wire lever_moved = push_lever != lever_q;
  wire [3:0] new_code = undervolt ? screwdriver_soft_start_pkg::F_UV :
    overtemp ? screwdriver_soft_start_pkg::F_OT :
    flash_fail ? screwdriver_soft_start_pkg::F_FLASH :
    (run_q & stall) ? screwdriver_soft_start_pkg::F_STALL :
    (run_q & lever_moved) ? screwdriver_soft_start_pkg::F_PUSH :
    (start_req & brake_in) ? screwdriver_soft_start_pkg::F_BRAKE :
    screwdriver_soft_start_pkg::F_NONE;
  wire fault_set = no_fault & (new_code != screwdriver_soft_start_pkg::F_NONE);
  wire lock_end = timed & (lock_cnt_q == CW'(LOCK_CYC - 1));
  wire fault_clr = lock_end | ((fault_q == screwdriver_soft_start_pkg::F_PUSH) & ~lever_moved)
    | ((fault_q == screwdriver_soft_start_pkg::F_BRAKE) & ~brake_in);
  assign fault_d = fault_set ? new_code : fault_clr ? screwdriver_soft_start_pkg::F_NONE : fault_q;
  wire [CW-1:0] lock_cnt_d = (timed & ~lock_end) ? lock_cnt_q + 1'b1 : '0;

  // ----------------------------------------
  // motor and soft start
  // ----------------------------------------
  wire run_d = trigger & no_fault & ~fault_set;
  wire start_edge = run_d & ~run_q;
  wire tick = soft_q & (tenth_cnt_q == CW'(TENTH_CYC - 1));
  wire [CW-1:0] tenth_cnt_d = (soft_q & ~tick & ~start_edge) ? tenth_cnt_q + 1'b1 : '0;
  wire soft_d = start_edge ? (level_q != 4'h0 && ramp_q != 7'h00)
    : soft_q & run_d & ~(tick & (left_q == 7'h01));
  wire [6:0] left_d = start_edge ? ramp_q : tick ? left_q - 7'h01 : left_q;
  wire [6:0] speed_d = ~run_d ? 7'h00 : soft_d ? reduced(level_q)
    : screwdriver_soft_start_pkg::SPD_FULL;
  wire lever_d = start_edge ? push_lever : lever_q;

  // ----------------------------------------
  // display
  // ----------------------------------------
  wire [7:0] dl_d = !no_fault ? screwdriver_soft_start_pkg::CH_FAULT :
    (in_ramp & ~shown_q) ? screwdriver_soft_start_pkg::CH_RP0 :
    in_ramp ? digit(4'(ramp_q / 7'd10)) :
    (in_rate & ~shown_q) ? screwdriver_soft_start_pkg::CH_SP0 :
    screwdriver_soft_start_pkg::CH_LEVEL;
  wire [7:0] dr_d = !no_fault ? digit(fault_q) :
    (in_ramp & ~shown_q) ? screwdriver_soft_start_pkg::CH_RP1 :
    in_ramp ? digit(4'(ramp_q % 7'd10)) :
    (in_rate & ~shown_q) ? screwdriver_soft_start_pkg::CH_SP1 :
    digit(level_q);

  // ----------------------------------------
  // status, mask and interrupt
  // ----------------------------------------
  function automatic logic [EW-1:0] fbit(logic [3:0] c);
    unique case (c)
      screwdriver_soft_start_pkg::F_UV: return 7'h01;
      screwdriver_soft_start_pkg::F_OT: return 7'h02;
      screwdriver_soft_start_pkg::F_STALL: return 7'h04;
      screwdriver_soft_start_pkg::F_PUSH: return 7'h08;
      screwdriver_soft_start_pkg::F_BRAKE: return 7'h10;
      screwdriver_soft_start_pkg::F_FLASH: return 7'h20;
      default: return 7'h00;
    endcase
  endfunction

  wire bus_wr = ~bvalid_q & aw_got_q & w_got_q;
  wire [31:0] wmask = wmerge(32'h0, wdata_q, wstrb_q);
  wire st_wr = bus_wr && waddr_q == screwdriver_soft_start_pkg::STATUS_OFF;
  wire mk_wr = bus_wr && waddr_q == screwdriver_soft_start_pkg::MASK_OFF;
  wire [EW-1:0] evt = (fault_set ? fbit(new_code) : 7'h00) | {start_edge, 6'h00};
  // a new event wins over a one written in the same cycle
  wire [EW-1:0] status_d = (status_q & ~(st_wr ? wmask[EW-1:0] : 7'h00)) | evt;
  wire [EW-1:0] mask_d = mk_wr ? wmask[EW-1:0] : mask_q;
  wire irq_d = |(status_d & mask_d);

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire b_hs = bvalid_q & bready;
  wire ar_hs = arvalid & arready_q;
  wire r_hs = rvalid_q & rready;
  wire wr_ok = waddr_q == screwdriver_soft_start_pkg::STATUS_OFF
    || waddr_q == screwdriver_soft_start_pkg::MASK_OFF || waddr_q == screwdriver_soft_start_pkg::CONFIG_OFF;
  wire [31:0] state_rd = {9'h0, speed_q, 6'h0, soft_q, run_q, 2'h0, menu_q, fault_q};
  wire rd_ok = araddr == screwdriver_soft_start_pkg::STATUS_OFF || araddr == screwdriver_soft_start_pkg::MASK_OFF
    || araddr == screwdriver_soft_start_pkg::CONFIG_OFF || araddr == screwdriver_soft_start_pkg::STATE_OFF;
  wire [31:0] rd_mux = (araddr == screwdriver_soft_start_pkg::STATUS_OFF) ? {25'h0, status_q} :
    (araddr == screwdriver_soft_start_pkg::MASK_OFF) ? {25'h0, mask_q} :
    (araddr == screwdriver_soft_start_pkg::CONFIG_OFF) ? cfg_rd :
    (araddr == screwdriver_soft_start_pkg::STATE_OFF) ? state_rd : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= screwdriver_soft_start_pkg::RESP_OKAY;
      waddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      awready_q <= (awready_q & ~aw_hs) | b_hs;
      wready_q <= (wready_q & ~w_hs) | b_hs;
      aw_got_q <= (aw_got_q | aw_hs) & ~b_hs;
      w_got_q <= (w_got_q | w_hs) & ~b_hs;
      bvalid_q <= (bvalid_q & ~bready) | bus_wr;
      if (bus_wr) bresp_q <= wr_ok ? screwdriver_soft_start_pkg::RESP_OKAY : screwdriver_soft_start_pkg::RESP_SLVERR;
      if (aw_hs) waddr_q <= awaddr;
      if (w_hs) wdata_q <= wdata;
      if (w_hs) wstrb_q <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= screwdriver_soft_start_pkg::RESP_OKAY;
    end else begin
      arready_q <= (arready_q & ~ar_hs) | r_hs;
      rvalid_q <= (rvalid_q & ~rready) | ar_hs;
      if (ar_hs) rdata_q <= rd_mux;
      if (ar_hs) rresp_q <= rd_ok ? screwdriver_soft_start_pkg::RESP_OKAY : screwdriver_soft_start_pkg::RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // block registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      menu_q <= screwdriver_soft_start_pkg::M_NORMAL;
      {up_q, dn_q, hold_done_q, shown_q, run_q, soft_q, lever_q} <= 7'h00;
      {hold_cnt_q, lock_cnt_q, tenth_cnt_q} <= '0;
      ramp_q <= screwdriver_soft_start_pkg::RAMP_RST;
      level_q <= screwdriver_soft_start_pkg::LVL_RST;
      fault_q <= screwdriver_soft_start_pkg::F_NONE;
      {left_q, speed_q} <= 14'h0;
    end else begin
      menu_q <= menu_d;
      {up_q, dn_q, hold_done_q, shown_q} <= {btn_up, btn_down, hold_done_d, shown_d};
      {run_q, soft_q, lever_q} <= {run_d, soft_d, lever_d};
      {hold_cnt_q, lock_cnt_q, tenth_cnt_q} <= {hold_cnt_d, lock_cnt_d, tenth_cnt_d};
      {ramp_q, level_q, fault_q} <= {ramp_d, level_d, fault_d};
      {left_q, speed_q} <= {left_d, speed_d};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {status_q, mask_q} <= 14'h0;
      {start_q, brake_q, rev_q, irq_q} <= 4'h0;
      dl_q <= screwdriver_soft_start_pkg::CH_LEVEL;
      dr_q <= screwdriver_soft_start_pkg::CH_ZERO;
    end else begin
      {status_q, mask_q, irq_q} <= {status_d, mask_d, irq_d};
      start_q <= run_d;
      brake_q <= brake_in;
      rev_q <= run_d & reverse_sel;
      {dl_q, dr_q} <= {dl_d, dr_d};
    end
  end

  assign {start_out, brake_out, reverse_out, irq} = {start_q, brake_q, rev_q, irq_q};
  assign {motor_speed, disp_left, disp_right} = {speed_q, dl_q, dr_q};
  assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
  assign {arready, rvalid, rdata, rresp} = {arready_q, rvalid_q, rdata_q, rresp_q};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence enter_s;
    in_normal && hold_hit;
  endsequence
  sequence soft_start_s;
    start_edge && soft_d;
  endsequence
  sequence uv_hit_s;
    no_fault && undervolt;
  endsequence

  start_relay_a: assert property (start_edge |=> start_out ##1 (start_out || !no_fault || !$past(trigger)))
    else $error("start relay not raised");
  brake_relay_a: assert property (brake_in |=> brake_out)
    else $error("brake relay not raised");
  rev_relay_a: assert property (run_d && reverse_sel |=> reverse_out && start_out)
    else $error("reverse relay wrong");
  menu_enter_a: assert property (enter_s |=> in_ramp ##1 dl_q == 8'h52 && dr_q == 8'h43)
    else $error("ramp menu prompt missing");
  ramp_range_a: assert property (ramp_q <= 7'h63)
    else $error("ramp time out of range");
  ramp_step_a: assert property (in_ramp && up_press && !cfg_wr && ramp_q != 7'h63
    |=> ramp_q == $past(ramp_q) + 7'h01)
    else $error("ramp step wrong");
  menu_adv_a: assert property (in_ramp && hold_hit |=> in_rate && !shown_q)
    else $error("rate menu not entered");
  level_step_a: assert property (in_rate && dn_press && !cfg_wr && level_q != 4'h0
    |=> level_q == $past(level_q) - 4'h1 && level_q <= 4'h9)
    else $error("level step wrong");
  full_rate_a: assert property (start_edge && level_q == 4'h0 |=> speed_q == 7'h64 && !soft_q)
    else $error("full rate start not at full speed");
  level_show_a: assert property (in_normal && no_fault && level_q != 4'h0 && $stable(level_q)
    |=> dl_q == 8'h4c && dr_q == 8'h30 + {4'h0, $past(level_q)})
    else $error("level not shown");
  uv_stop_a: assert property (uv_hit_s |=> fault_q == 4'h3 && !start_out ##1 dr_q == 8'h33)
    else $error("undervoltage not handled");
  ot_stop_a: assert property (no_fault && overtemp && !undervolt |=> fault_q == 4'h4 && !start_out)
    else $error("overtemperature not handled");
  stall_stop_a: assert property (no_fault && run_q && stall && !undervolt && !overtemp && !flash_fail
    |=> fault_q == 4'h5 && motor_speed == 7'h00)
    else $error("stall not handled");
  flash_stop_a: assert property (no_fault && flash_fail && !undervolt && !overtemp
    |=> fault_q == 4'h9 ##1 dl_q == 8'h45)
    else $error("flash failure not handled");
  lock_hold_a: assert property (timed && lock_cnt_q != CW'(LOCK_CYC - 1)
    |=> fault_q == $past(fault_q) && !start_out)
    else $error("lockout ended early");
  push_hold_a: assert property (fault_q == 4'h7 && lever_moved |=> fault_q == 4'h7 && !start_out)
    else $error("push lever fault released early");
  brake_flt_a: assert property (start_req && brake_in && new_code == 4'h8 |=> fault_q == 4'h8 && !run_q)
    else $error("brake fault missed");
  soft_speed_a: assert property (soft_start_s |=> soft_q && speed_q == reduced($past(level_q)))
    else $error("soft start speed wrong");
endmodule

// ### bench/plc_model.sv
// external controller model that watches the three relay outputs
module plc_model (
  // relay inputs
  input wire logic aclk,
  input wire logic start_out,
  input wire logic brake_out,
  input wire logic reverse_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // start, brake and reverse bookkeeping
  // ----------------------------------------
  int starts = 0;
  int rev_starts = 0;
  int brakes = 0;
  logic prev_q = 1'b0;
  always @(posedge aclk) begin
    prev_q <= start_out;
    if (brake_out) brakes <= brakes + 1;
    if (start_out && !prev_q) begin
      starts <= starts + 1;
      if (reverse_out) rev_starts <= rev_starts + 1;
    end
  end
endmodule

// ### bench/tb_screwdriver_soft_start_ctrl.sv
// self-checking bench of the screwdriver soft-start controller
`define P(x) screwdriver_soft_start_pkg::x
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_screwdriver_soft_start_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic aclk = 0, aresetn = 0, btn_up = 0, btn_down = 0, trigger = 0, reverse_sel = 0;
  logic push_lever = 0, brake_in = 0, undervolt = 0, overtemp = 0, stall = 0, flash_fail = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic start_out, brake_out, reverse_out, irq, awready, wready, bvalid, arready, rvalid;
  logic [6:0] motor_speed;
  logic [7:0] disp_left, disp_right;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q[$];
  logic [33:0] exp_v;
  logic [3:0] fc [4] = '{`P(F_UV), `P(F_OT), `P(F_STALL), `P(F_FLASH)};
  int error_cnt = 0, num_checks = 0, cyc_cnt = 0, n = 0, r = 0;
  screwdriver_soft_start_ctrl #(.ENTER_CYC(20), .ADV_CYC(10), .LOCK_CYC(50), .TENTH_CYC(4))
    dut_u (.*);
  plc_model plc_u (.*);
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  always @(posedge aclk) if (rvalid && rready) begin
    exp_v = exp_q.pop_front();
    `CHK({rresp, rdata}, exp_v)
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic at(input int k);
    repeat (k) @(negedge aclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ap, dp;
    ap = 1;
    dp = 1;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    while (ap || dp) begin
      @(posedge aclk);
      if (ap && awready) begin ap = 0; awvalid <= 0; end
      if (dp && wready) begin dp = 0; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    `CHK(bresp, `P(RESP_OKAY))
  endtask
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    exp_q.push_back(e);
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask
  task automatic hold(input int k);
    @(posedge aclk);
    {btn_up, btn_down} <= 2'h3;
    repeat (k) @(posedge aclk);
    {btn_up, btn_down} <= 2'h0;
    at(3);
  endtask
  task automatic press(input logic u);
    @(posedge aclk);
    {btn_up, btn_down} <= {u, !u};
    at(2);
    @(posedge aclk);
    {btn_up, btn_down} <= 2'h0;
    at(2);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(92));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    hold(24);
    `CHK({disp_left, disp_right}, {`P(CH_RP0), `P(CH_RP1)})
    n = $urandom_range(5, 1);
    press(0);
    repeat (n) press(1);
    `CHK({disp_left, disp_right}, {`P(CH_ZERO), 8'h30 + 8'(n)})
    rd(`P(CONFIG_OFF), {`P(RESP_OKAY), 25'h0, 7'(n)});
    hold(14);
    `CHK({disp_left, disp_right}, {`P(CH_SP0), `P(CH_SP1)})
    press(1);
    press(1);
    press(0);
    `CHK({disp_left, disp_right}, {`P(CH_LEVEL), 8'h31})
    hold(14);
    rd(`P(CONFIG_OFF), {`P(RESP_OKAY), 20'h0, 4'h1, 1'b0, 7'(n)});
    rd(32'h0000_0010, {`P(RESP_SLVERR), 32'h0});
    $display("panel test done");
    wr(`P(MASK_OFF), 32'h1);
    for (int l = 0; l < 10; l++) begin
      r = $urandom_range(4, 1);
      wr(`P(CONFIG_OFF), 32'((l << 8) | r));
      @(posedge aclk);
      {trigger, reverse_sel} <= {1'b1, l[0]};
      n = 0;
      do begin at(1); n++; end while (start_out !== 1'b1 && n < 5);
      `CHK(reverse_out, l[0])
      `CHK(motor_speed, l ? 7'(30 + 60 * (l - 1) / 8) : `P(SPD_FULL))
      // a few cycles of slack: the start relay lags the run request by one clock
      at(r * 4 - 2);
      if (l > 0) `CHK(motor_speed, 7'(30 + 60 * (l - 1) / 8))
      at(5);
      `CHK(motor_speed, `P(SPD_FULL))
      @(posedge aclk);
      trigger <= 0;
      at(3);
    end
    `CHK(irq, 1'b0)
    `CHK(plc_u.starts, 10)
    `CHK(plc_u.rev_starts, 5)
    rd(`P(STATUS_OFF), {`P(RESP_OKAY), 32'h40});
    $display("soft start test done");
    @(posedge aclk);
    trigger <= 1;
    at(4);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      {flash_fail, stall, overtemp, undervolt} <= 4'h1 << i;
      at(3);
      `CHK({start_out, disp_left, disp_right}, {1'b0, `P(CH_FAULT), 4'h3, fc[i]})
      if (i == 0) `CHK(irq, 1'b1)
      @(posedge aclk);
      {flash_fail, stall, overtemp, undervolt} <= 4'h0;
      at(40);
      `CHK(disp_left, `P(CH_FAULT))
      at(12);
      `CHK({start_out, disp_left}, {1'b1, `P(CH_LEVEL)})
    end
    wr(`P(STATUS_OFF), 32'h7f);
    at(2);
    `CHK(irq, 1'b0)
    @(posedge aclk);
    push_lever <= 1;
    at(3);
    `CHK({start_out, disp_right}, {1'b0, 4'h3, `P(F_PUSH)})
    @(posedge aclk);
    {push_lever, trigger} <= 2'h0;
    at(3);
    `CHK(disp_left, `P(CH_LEVEL))
    @(posedge aclk);
    brake_in <= 1;
    at(2);
    `CHK(brake_out, 1'b1)
    @(posedge aclk);
    trigger <= 1;
    at(3);
    `CHK({start_out, disp_right}, {1'b0, 4'h3, `P(F_BRAKE)})
    @(posedge aclk);
    brake_in <= 0;
    at(3);
    `CHK(disp_left, `P(CH_LEVEL))
    $display("fault test done");
    end_sim();
  end
endmodule
